// [rtc_timer.sv]
// Purpose: 16-bit reload / edge-counting timer with latched count read
// Assumes: inputs synchronous to ref_clk_i; timer input toggles slowly
// Notes:   prescale value 0 acts as 256
//
// Design decisions made here: the strobed register port and the address map.
`include "rtc_params.svh"

module rtc_timer
  import rtc_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              rst_n_i,
  input  wire rtc_pkg::rtc_bus_req_t bus_i,
  output logic [7:0]             rdata_o,
  input  wire logic              timer_in_i,
  output logic                   timer_out_o,
  output logic                   timer_req_o,
  output logic                   irq_o
);
  import rtc_pkg::*;

  // ==========================================================
  // register decode
  logic [15:0] count_reg;
  logic [15:0] reload_reg;
  logic [7:0]  ctrl_reg;
  logic [7:0]  prescale_reg;
  logic [7:0]  prescale_cnt_reg;
  logic [7:0]  count_low_read_reg;
  logic [1:0]  status_reg;
  logic [1:0]  mask_reg;
  logic        in_prev_reg;
  logic        out_reg;
  logic        req_reg;
  logic [7:0]  rdata_reg;

  wire wr_hi    = bus_i.wr && bus_i.addr == `RTC_OFS_CNT_HI;
  wire wr_lo    = bus_i.wr && bus_i.addr == `RTC_OFS_CNT_LO;
  wire wr_ctrl  = bus_i.wr && bus_i.addr == `RTC_OFS_CTRL;
  wire rd_hi    = bus_i.rd && bus_i.addr == `RTC_OFS_CNT_HI;
  wire enabled  = ctrl_reg[`RTC_CTRL_EN];
  wire edge_mode = ctrl_reg[`RTC_CTRL_MODE];
  wire edge_polarity_select = ctrl_reg[`RTC_CTRL_POL];
  wire enable_rise = wr_ctrl && bus_i.wdata[`RTC_CTRL_EN] && !enabled;

  // ==========================================================
  // tick generation
  wire prescale_done = (prescale_cnt_reg == prescale_reg - 8'h01);
  wire clk_tick  = enabled && !edge_mode && prescale_done;
  wire in_edge   = edge_polarity_select ? (!in_prev_reg && timer_in_i)
                                        : (in_prev_reg && !timer_in_i);
  wire edge_tick = enabled && edge_mode && in_edge;
  wire tick      = clk_tick || edge_tick;
  wire at_reload = (count_reg == reload_reg);
  wire do_reload = tick && at_reload && !edge_mode;
  wire edge_wrap = tick && at_reload && edge_mode;

  logic [15:0] count_next;
  always_comb
  begin
    count_next = count_reg;
    if (do_reload || edge_wrap)
      count_next = `RTC_COUNT_ONE;
    else if (tick)
      count_next = count_reg + 16'h0001;
    // software byte writes win over the tick in the same cycle
    if (wr_hi)
      count_next[15:8] = bus_i.wdata;
    if (wr_lo)
      count_next[7:0] = bus_i.wdata;
  end

  // read mux: low byte comes from the hold register only while enabled
  logic [7:0] rd_mux;
  always_comb
  begin
    unique case (bus_i.addr)
      `RTC_OFS_CNT_HI:   rd_mux = count_reg[15:8];
      `RTC_OFS_CNT_LO:   rd_mux = enabled ? count_low_read_reg
                                          : count_reg[7:0];
      `RTC_OFS_RLD_HI:   rd_mux = reload_reg[15:8];
      `RTC_OFS_RLD_LO:   rd_mux = reload_reg[7:0];
      `RTC_OFS_CTRL:     rd_mux = ctrl_reg;
      `RTC_OFS_PRESCALE: rd_mux = prescale_reg;
      `RTC_OFS_STATUS:   rd_mux = {6'h00, status_reg};
      `RTC_OFS_MASK:     rd_mux = {6'h00, mask_reg};
      default:           rd_mux = 8'h00;
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      count_reg          <= `RTC_RST_COUNT;
      reload_reg         <= `RTC_RST_RELOAD;
      ctrl_reg           <= `RTC_RST_BYTE;
      prescale_reg       <= `RTC_RST_PRESCALE;
      prescale_cnt_reg   <= `RTC_RST_BYTE;
      count_low_read_reg <= `RTC_RST_BYTE;
      status_reg         <= 2'b00;
      mask_reg           <= 2'b00;
      in_prev_reg        <= 1'b0;
      out_reg            <= 1'b0;
      req_reg            <= 1'b0;
      rdata_reg          <= `RTC_RST_BYTE;
    end
    else
    begin
      count_reg   <= count_next;
      in_prev_reg <= timer_in_i;
      req_reg     <= do_reload;
      rdata_reg   <= bus_i.rd ? rd_mux : 8'h00;
      // prescaler only runs in auto-reload mode
      if (!enabled || edge_mode || prescale_done)
        prescale_cnt_reg <= 8'h00;
      else
        prescale_cnt_reg <= prescale_cnt_reg + 8'h01;
      if (rd_hi && enabled)
        count_low_read_reg <= count_reg[7:0];
      if (wr_ctrl)
        ctrl_reg <= bus_i.wdata;
      if (enable_rise)
        out_reg <= bus_i.wdata[`RTC_CTRL_OUTINIT];
      else if (do_reload)
        out_reg <= !out_reg;
      if (bus_i.wr && bus_i.addr == `RTC_OFS_RLD_HI)
        reload_reg[15:8] <= bus_i.wdata;
      if (bus_i.wr && bus_i.addr == `RTC_OFS_RLD_LO)
        reload_reg[7:0] <= bus_i.wdata;
      if (bus_i.wr && bus_i.addr == `RTC_OFS_PRESCALE)
        prescale_reg <= bus_i.wdata;
      if (bus_i.wr && bus_i.addr == `RTC_OFS_MASK)
        mask_reg <= bus_i.wdata[1:0];
      // set wins over write-one-to-clear
      status_reg[`RTC_ST_RELOAD] <= do_reload || (status_reg[`RTC_ST_RELOAD] &&
        !(bus_i.wr && bus_i.addr == `RTC_OFS_STATUS && bus_i.wdata[`RTC_ST_RELOAD]));
      status_reg[`RTC_ST_EDGE] <= edge_tick || (status_reg[`RTC_ST_EDGE] &&
        !(bus_i.wr && bus_i.addr == `RTC_OFS_STATUS && bus_i.wdata[`RTC_ST_EDGE]));
    end
  end

  assign rdata_o     = rdata_reg;
  assign timer_out_o = out_reg;
  assign timer_req_o = req_reg;
  assign irq_o       = |(status_reg & mask_reg);

  // ==========================================================
  // checks
  a_reload_to_one: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    do_reload && !wr_hi && !wr_lo |=> count_reg == `RTC_COUNT_ONE)
    else $error("count not one after reload");
  a_reload_pulse: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    do_reload |=> timer_req_o ##1 !timer_req_o || $past(do_reload, 1))
    else $error("reload request not a single pulse");
  a_out_toggle: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    do_reload && !enable_rise |=> timer_out_o != $past(timer_out_o))
    else $error("output did not toggle on reload");
  a_hold_latch: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rd_hi && enabled |=> count_low_read_reg == $past(count_reg[7:0]))
    else $error("low byte not held on high read");
  a_live_low: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    bus_i.rd && bus_i.addr == `RTC_OFS_CNT_LO && !enabled
    |=> rdata_o == $past(count_reg[7:0]))
    else $error("live low byte not returned while disabled");
  a_write_high: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_hi |=> count_reg[15:8] == $past(bus_i.wdata))
    else $error("high byte write not loaded");
  a_no_pin_reload: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !edge_mode && !prescale_done |-> !tick)
    else $error("auto-reload counted without prescale tick");
  a_edge_step: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    edge_tick && !at_reload && !wr_hi && !wr_lo |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("edge did not advance count");
  a_read_quiet: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    enabled && !tick && !bus_i.wr |=> $stable(count_reg))
    else $error("count changed without tick or write");
  a_edge_wrap_one: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    edge_wrap && !wr_hi && !wr_lo |=> count_reg == `RTC_COUNT_ONE)
    else $error("edge count did not wrap to one");
  a_reload_flag: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    do_reload |=> status_reg[`RTC_ST_RELOAD])
    else $error("reload status not set");
endmodule

// [rtc_params.svh]
// Purpose: constants for the reload timer with count read-back
// Assumes: 8-bit register port, one 50 MHz clock
// Notes:   offsets are register indices on the plain port
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH
// ==========================================================
// register offsets
`define RTC_OFS_CNT_HI   4'h0
`define RTC_OFS_CNT_LO   4'h1
`define RTC_OFS_RLD_HI   4'h2
`define RTC_OFS_RLD_LO   4'h3
`define RTC_OFS_CTRL     4'h4
`define RTC_OFS_PRESCALE 4'h5
`define RTC_OFS_STATUS   4'h6
`define RTC_OFS_MASK     4'h7
// ==========================================================
// control field positions
`define RTC_CTRL_EN      0
`define RTC_CTRL_MODE    1
`define RTC_CTRL_POL     2
`define RTC_CTRL_OUTINIT 3
// status field positions
`define RTC_ST_RELOAD    0
`define RTC_ST_EDGE      1
// ==========================================================
// reset values
`define RTC_RST_COUNT    16'h0001
`define RTC_RST_RELOAD   16'hFFFF
`define RTC_RST_BYTE     8'h00
`define RTC_RST_PRESCALE 8'h01
`define RTC_COUNT_ONE    16'h0001
`endif

// [rtc_pkg.sv]
// Purpose: types for the reload timer with count read-back
// Assumes: nothing beyond the params header
// Notes:   none
package rtc_pkg;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rtc_bus_req_t;
  typedef enum logic [1:0] {
    RTC_MODE_RELOAD = 2'b01,
    RTC_MODE_EDGE   = 2'b10
  } rtc_mode_t;
endpackage

// [rtc_pin_model.sv]
// Purpose: timer input pin source standing in for the outside world
// Assumes: a fire pulse loads how many high pulses to send
// Notes:   pin toggles every 4 clocks, rests low between bursts
module rtc_pin_model
(
  input  wire logic       ref_clk_i,
  input  wire logic       fire_i,
  input  wire logic [7:0] pulses_i,
  output logic            pin_o
);
  logic [7:0] left_reg = 8'h00;
  logic [2:0] ph_reg   = 3'h0;
  initial pin_o = 1'b0;
  // ==========================================================
  // burst generator
  always @(posedge ref_clk_i)
  begin
    if (fire_i)
    begin
      left_reg <= pulses_i;
      ph_reg   <= 3'h0;
    end
    else if (left_reg != 8'h00)
    begin
      ph_reg <= ph_reg + 3'h1;
      pin_o  <= (ph_reg < 3'h4);
      if (ph_reg == 3'h7)
        left_reg <= left_reg - 8'h01;
    end
  end
endmodule

// [testbench.sv]
// Purpose: self-checking bench for the reload timer
// Assumes: register map and bits from the params header
// Notes:   no checker here, assertions live beside the logic
`include "rtc_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import rtc_pkg::*;
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, fire = 1'b0;
  logic timer_in_i, timer_out_o, timer_req_o, irq_o;
  logic [7:0] rdata_o, npulse = 8'h00;
  rtc_bus_req_t bus_i = '0;
  int mismatches = 0, checks = 0;
  always #10 ref_clk_i = ~ref_clk_i;
  rtc_timer rtc_timer_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .timer_in_i(timer_in_i), .timer_out_o(timer_out_o),
    .timer_req_o(timer_req_o), .irq_o(irq_o));
  rtc_pin_model rtc_pin_model_inst (.ref_clk_i(ref_clk_i), .fire_i(fire),
    .pulses_i(npulse), .pin_o(timer_in_i));
  // ==========================================================
  // bus and compare helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    bus_i <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk_i);
    bus_i <= '0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    bus_i <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk_i);
    bus_i <= '0;
    @(negedge ref_clk_i);
    d = rdata_o;
  endtask
  task automatic setup(input logic [7:0] ctl, pre, input logic [15:0] cnt, rld);
    wr(`RTC_OFS_CTRL, 8'h00);
    wr(`RTC_OFS_PRESCALE, pre);
    wr(`RTC_OFS_CNT_HI, cnt[15:8]);
    wr(`RTC_OFS_CNT_LO, cnt[7:0]);
    wr(`RTC_OFS_RLD_HI, rld[15:8]);
    wr(`RTC_OFS_RLD_LO, rld[7:0]);
    wr(`RTC_OFS_CTRL, ctl);
  endtask
  task automatic gap_to_req(input int exp);
    int n;
    n = 0;
    do begin @(negedge ref_clk_i); n++; end while (timer_req_o !== 1'b1 && n < 2000);
    chk(16'(n), 16'(exp));
  endtask
  // ==========================================================
  // scenarios
  task automatic reload_run(input logic [7:0] pre, input logic [15:0] st, rld);
    logic o;
    setup(8'h09, pre, st, rld);
    // output level settles after the enabling edge
    @(negedge ref_clk_i);
    o = timer_out_o;
    chk({15'h0, o}, 16'h0001);
    gap_to_req((rld - st + 1) * pre);
    chk({15'h0, timer_out_o}, 16'h0000);
    gap_to_req(rld * pre);
    gap_to_req(rld * pre);
    chk({15'h0, timer_out_o}, 16'h0000);
  endtask
  task automatic edge_run(input logic [7:0] ctl);
    logic [7:0] h, l;
    setup(ctl, 8'h04, 16'h0001, 16'hFFFF);
    @(posedge ref_clk_i);
    fire <= 1'b1;
    npulse <= 8'h05;
    @(posedge ref_clk_i);
    fire <= 1'b0;
    repeat (48) @(posedge ref_clk_i);
    wr(`RTC_OFS_CTRL, 8'h00);
    rd(`RTC_OFS_CNT_HI, h);
    rd(`RTC_OFS_CNT_LO, l);
    chk({h, l}, 16'h0006);
  endtask
  task automatic latch_run;
    logic [7:0] h, l1, l2;
    setup(8'h01, 8'h01, 16'h0010, 16'hFFFF);
    rd(`RTC_OFS_CNT_HI, h);
    chk({8'h00, h}, 16'h0000);
    rd(`RTC_OFS_CNT_LO, l1);
    chk({8'h00, l1}, 16'h0011);
    repeat (5) @(posedge ref_clk_i);
    rd(`RTC_OFS_CNT_LO, l2);
    chk({8'h00, l2}, {8'h00, l1});
    wr(`RTC_OFS_CTRL, 8'h00);
    wr(`RTC_OFS_CNT_LO, 8'h33);
    rd(`RTC_OFS_CNT_LO, l1);
    chk({8'h00, l1}, 16'h0033);
  endtask
  task automatic irq_run;
    logic [7:0] s;
    rd(`RTC_OFS_STATUS, s);
    chk({8'h00, s}, 16'h0003);
    wr(`RTC_OFS_MASK, 8'h00);
    @(negedge ref_clk_i);
    chk({15'h0, irq_o}, 16'h0000);
    wr(`RTC_OFS_MASK, 8'h01);
    @(negedge ref_clk_i);
    chk({15'h0, irq_o}, 16'h0001);
    wr(`RTC_OFS_STATUS, 8'h03);
    @(negedge ref_clk_i);
    chk({15'h0, irq_o}, 16'h0000);
    rd(4'hF, s);
    chk({8'h00, s}, 16'h0000);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    mismatches++;
    wrap_up();
  end
  initial
  begin
    repeat (6) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    reload_run(8'h01, 16'h0002, 16'h0005);
    reload_run(8'h03, 16'h0001, 16'h0004);
    edge_run(8'h07);
    edge_run(8'h03);
    latch_run();
    irq_run();
    wrap_up();
  end
endmodule
